// ===== core/otp_access_pkg.sv
// Shared constants and carriers for the one-time-programmable memory access block.
// Assumes a single 250 MHz system clock and one user of the package.
package otp_access_pkg;
  localparam int          PROG_BYTES   = 16384;   // Bytes visible to the programmer
  localparam int          CELL_WORDS   = 8192;    // 16-bit cells in the array
  localparam int          BYTE_AW      = 14;
  localparam int          WORD_AW      = 13;
  localparam logic [7:0]  ERASED_BYTE  = 8'hFF;
  localparam logic [15:0] ERASED_WORD  = 16'hFFFF;
  localparam logic [7:0]  ENCRYPT_KEY  = 8'hA5;   // Scrambles programmer array reads at level 1
  localparam logic [2:0]  CFG_SIX_IDX  = 3'h6;
  localparam logic [2:0]  CFG_SEVEN_IDX = 3'h7;
  localparam int          SEC_LSB      = 0;       // Security field in byte seven
  localparam logic [1:0]  LVL_FULL     = 2'h3;
  localparam logic [1:0]  LVL_WPROT    = 2'h2;
  localparam logic [1:0]  LVL_ENCRYPT  = 2'h1;
  localparam logic [1:0]  LVL_LOCKED   = 2'h0;
  localparam logic [12:0] LAST_WORD    = 13'h1FFF;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_WAIT = 2'h1,
    ST_DONE = 2'h3
  } acc_state_e;

  typedef struct packed {
    logic                we;        // Program rather than verify
    logic                cfg;       // Configuration byte space
    logic                ptr_load;  // Load the pointer from wdata
    logic [BYTE_AW-1:0]  addr;
    logic [7:0]          wdata;
  } prog_req_s;

  typedef struct packed {
    logic                operand;   // Operand read, not an opcode fetch
    logic                internal;  // Requesting opcode came from the array
    logic                vector;    // Interrupt vector fetch
    logic [WORD_AW-1:0]  addr;
  } cpu_req_s;
endpackage

// ===== core/otp_memory_mode_and_security.sv
// Program memory array with programming mode, configuration bytes and security.
// Assumes all inputs synchronous to clk_sys_i; the array and configuration bytes
// are nonvolatile and hold no reset, so an erase pulse must precede first use.
// The programmer and the core share one sequencer; the voltage pin picks the side it serves, and the other side waits for the mode to change.
`timescale 1ns/1ps

// Notes on behaviour
// - Two modes: programming and normal running
// - Programmer sees exactly 16 kbytes
// - Programming mode only under high voltage
// - Erase sets ones; programming only clears
// - Ones in data leave bits unchanged
// - Configuration bytes outside program address space
// - Configuration bytes programmed only through pointer
// - Pointer and address must match
// - External select latched at reset release
// - Running mode reads 16-bit words only
// - One wait state on every access
// - Two bits decode four security levels
// - Erased security bits mean level 3
// - Level 3: full programming-mode access
// - Level 3: unrestricted running reads
// - Level 2: no programming, reads free
// - Level 1: no programming, encrypted programmer memory reads
// - Protected external operand reads return ones
// - Level 0: programmer memory reads return ones
module otp_memory_mode_and_security
  import otp_access_pkg::*;
(
  input  wire logic                      clk_sys_i,     // System clock
  input  wire logic                      sys_rst_i,     // Async reset, high
  input  wire logic                      prog_voltage_i, // Programming voltage present
  input  wire logic                      ext_mem_sel_i, // External memory select
  input  wire logic                      uv_erase_i,    // Erase pulse
  input  wire logic                      prog_valid_i,  // Programmer request
  input  wire otp_access_pkg::prog_req_s prog_req_i,    // Programmer request fields
  input  wire logic                      cpu_valid_i,   // Core fetch request
  input  wire otp_access_pkg::cpu_req_s  cpu_req_i,     // Core fetch fields
  output logic                           prog_ready_o,  // Programmer request taken
  output logic                           prog_ack_o,    // Programmer answer pulse
  output logic [7:0]                     prog_rdata_o,  // Programmer read byte
  output logic                           cpu_ready_o,   // Core request taken
  output logic                           cpu_ack_o,     // Core answer pulse
  output logic [15:0]                    cpu_rdata_o,   // Core read word
  output logic                           refused_o,     // Write refused, with ack
  output logic                           prog_mode_o,   // Programming mode active
  output logic [1:0]                     sec_level_o,   // Latched security level
  output logic                           ext_mem_sel_o, // Latched external select
  output logic                           erase_busy_o   // Erase sweep running
);
  import otp_access_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // State
  // The cell array is large; it stays a plain array so it can map onto a memory
  acc_state_e          st_q;
  logic                is_prog_q;
  prog_req_s           preq_q;
  cpu_req_s            creq_q;
  logic [2:0]          ptr_q;
  logic [1:0]          sec_q;
  logic                sec_ready_q;
  logic                ext_q;
  logic                ext_done_q;
  logic                erase_q;
  logic [WORD_AW-1:0]  erase_cnt_q;
  logic [15:0]         data_q;
  logic                refused_q;
  logic [15:0]         cell_q [CELL_WORDS];
  logic [7:0]          cfg_six_q;
  logic [7:0]          cfg_seven_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Request decode
  // The voltage pin alone picks which side may start; the level must be loaded and no sweep running
  wire prog_mode   = prog_voltage_i;
  wire idle_ok     = (st_q == ST_IDLE) && sec_ready_q && !erase_q;
  wire take_prog   = idle_ok && prog_mode && prog_valid_i;
  wire take_cpu    = idle_ok && !prog_mode && cpu_valid_i;
  wire take        = take_prog || take_cpu;
  // Write qualification; a refused write still answers, so the programmer never hangs
  wire write_ok    = (sec_q == LVL_FULL);
  wire [WORD_AW-1:0] p_word = preq_q.addr[BYTE_AW-1:1];
  wire p_lane      = preq_q.addr[0];
  wire p_mem       = !preq_q.cfg && !preq_q.ptr_load;
  wire cfg_hit     = preq_q.cfg && !preq_q.ptr_load && (preq_q.addr[2:0] == ptr_q);
  wire at_op       = (st_q == ST_WAIT);
  wire want_wr     = at_op && is_prog_q && preq_q.we && (p_mem || cfg_hit);
  wire mem_we      = want_wr && write_ok && p_mem;
  wire cfg_we      = want_wr && write_ok && cfg_hit;
  wire wr_refused  = at_op && is_prog_q && preq_q.we && !preq_q.ptr_load && !(mem_we || cfg_we);

  ////////////////////////////////////////////////////////////////////////////////
  // Read data selection; clearing mask keeps ones as they are
  wire [15:0] p_cell   = cell_q[p_word];
  wire [7:0]  p_byte   = p_lane ? p_cell[15:8] : p_cell[7:0];
  wire [15:0] clr_mask = p_lane ? {preq_q.wdata, ERASED_BYTE} : {ERASED_BYTE, preq_q.wdata};
  wire [7:0]  cfg_byte = (preq_q.addr[2:0] == CFG_SIX_IDX)   ? cfg_six_q :
                         (preq_q.addr[2:0] == CFG_SEVEN_IDX) ? cfg_seven_q : ERASED_BYTE;
  // Level 2 and 3 read plainly; level 1 scrambles; level 0 hides the array
  wire [7:0]  mem_rd   = (sec_q == LVL_LOCKED)  ? ERASED_BYTE :
                         (sec_q == LVL_ENCRYPT) ? (p_byte ^ ENCRYPT_KEY) :
                         p_byte;
  // Configuration bytes read plainly at every level; only the array is guarded
  wire [7:0]  prog_rd  = preq_q.cfg ? cfg_byte : mem_rd;
  // Jumps and vectors pass; below level 2 foreign operand reads see all ones
  wire cpu_block = (sec_q < LVL_WPROT) && creq_q.operand && !creq_q.internal && !creq_q.vector;
  wire [15:0] cpu_rd   = cpu_block ? ERASED_WORD : cell_q[creq_q.addr];

  ////////////////////////////////////////////////////////////////////////////////
  // Access sequencer: take, one wait state, answer
  // The fixed wait state keeps the array read path off the critical timing path
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_q <= ST_IDLE;
    end else begin
      case (st_q)
        ST_IDLE: st_q <= take ? ST_WAIT : ST_IDLE;
        ST_WAIT: st_q <= ST_DONE;
        ST_DONE: st_q <= ST_IDLE;
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // Request capture and registered answer
  // Both request words are captured on every take; only the side that was taken is used
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      is_prog_q <= 1'b0;
      preq_q    <= '0;
      creq_q    <= '0;
      data_q    <= 16'h0000;
      refused_q <= 1'b0;
      ptr_q     <= 3'h0;
    end else begin
      if (take) begin
        is_prog_q <= take_prog;
        preq_q    <= prog_req_i;
        creq_q    <= cpu_req_i;
      end
      if (at_op) begin
        data_q    <= is_prog_q ? {8'h00, prog_rd} : cpu_rd;
        refused_q <= wr_refused;
      end
      if (at_op && is_prog_q && preq_q.ptr_load) begin
        ptr_q <= preq_q.wdata[2:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Security level and external select, caught after reset release
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sec_q       <= LVL_LOCKED;
      sec_ready_q <= 1'b0;
      ext_q       <= 1'b0;
      ext_done_q  <= 1'b0;
    end else begin
      // Loading waits for the sweep to end, so a half-erased byte is never taken as the level
      if (!sec_ready_q && !erase_q) begin
        sec_q       <= cfg_seven_q[SEC_LSB +: 2];
        sec_ready_q <= 1'b1;
      end else if (erase_q) begin
        sec_ready_q <= 1'b0;   // Re-read the cells once the sweep ends
      end
      // Latched once per reset; only a fresh reset pulse can change the choice
      if (!ext_done_q) begin
        ext_q      <= ext_mem_sel_i;
        ext_done_q <= 1'b1;
      end
    end
  end

  // Erase sweep counter; requests wait while it runs
  // A request taken on the same edge wins and the erase pulse is dropped, so no access overlaps a sweep
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      erase_q     <= 1'b0;
      erase_cnt_q <= '0;
    end else if (erase_q) begin
      erase_cnt_q <= WORD_AW'(erase_cnt_q + 1'b1);
      erase_q     <= (erase_cnt_q != LAST_WORD);
    end else if (uv_erase_i && st_q == ST_IDLE && !take) begin
      erase_q     <= 1'b1;
      erase_cnt_q <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Nonvolatile cells: no reset, only erase and bit clearing change them
  // Clearing is an AND with the presented byte, so a one can never be written back
  always_ff @(posedge clk_sys_i) begin
    if (erase_q) begin
      cell_q[erase_cnt_q] <= ERASED_WORD;
    end else if (mem_we) begin
      cell_q[p_word] <= p_cell & clr_mask;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (erase_q) begin
      cfg_six_q   <= ERASED_BYTE;
      cfg_seven_q <= ERASED_BYTE;
    end else if (cfg_we && ptr_q == CFG_SIX_IDX) begin
      cfg_six_q   <= cfg_six_q & preq_q.wdata;
    end else if (cfg_we && ptr_q == CFG_SEVEN_IDX) begin
      cfg_seven_q <= cfg_seven_q & preq_q.wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs
  // Handshake outputs are combinational; data outputs come straight from flip-flops
  assign prog_ready_o  = take_prog;
  assign cpu_ready_o   = take_cpu;
  assign prog_ack_o    = (st_q == ST_DONE) && is_prog_q;
  assign cpu_ack_o     = (st_q == ST_DONE) && !is_prog_q;
  assign prog_rdata_o  = data_q[7:0];
  assign cpu_rdata_o   = data_q;
  assign refused_o     = refused_q && (st_q == ST_DONE);
  assign prog_mode_o   = prog_mode;
  assign sec_level_o   = sec_q;
  assign ext_mem_sel_o = ext_q;
  assign erase_busy_o  = erase_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  // Access timing is a two-step sequence: the wait state, then the answer
  sequence seq_wait_ack;
    (st_q == ST_WAIT) ##1 (prog_ack_o || cpu_ack_o);
  endsequence

  chk_one_wait_state: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    take |=> seq_wait_ack) else $error("access did not answer after one wait state");

  // Security: what each level lets through
  chk_runtime_ones: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (take_cpu && sec_q < LVL_WPROT && cpu_req_i.operand && !cpu_req_i.internal && !cpu_req_i.vector)
    |-> ##2 (cpu_ack_o && cpu_rdata_o == ERASED_WORD)) else $error("protected operand read leaked");

  chk_locked_read: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (take_prog && sec_q == LVL_LOCKED && !prog_req_i.cfg && !prog_req_i.ptr_load)
    |-> ##2 (prog_ack_o && prog_rdata_o == ERASED_BYTE)) else $error("locked array read not ones");

  chk_no_write_prot: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (mem_we || cfg_we) |-> (sec_q == LVL_FULL)) else $error("write below level 3");

  // Latches and mode gating
  chk_ext_held: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    $past(ext_done_q) |-> $stable(ext_q)) else $error("external select changed while running");

  chk_ptr_match: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    cfg_we |-> (preq_q.addr[2:0] == ptr_q && preq_q.cfg)) else $error("config write without pointer match");

  chk_mode_gate: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    take_prog |-> prog_voltage_i && !cpu_ready_o) else $error("programmer taken without voltage");

  chk_sec_first: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    !sec_ready_q |-> !take) else $error("access before security evaluated");

  chk_encrypt_read: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (at_op && is_prog_q && p_mem && sec_q == LVL_ENCRYPT) |=> (data_q[7:0] == ($past(p_byte) ^ ENCRYPT_KEY)))
    else $error("level 1 read not scrambled");

  // Array contents: zeros presented clear, ones presented keep, nothing rises
  chk_clear_only: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    mem_we |=> (((cell_q[$past(p_word)] & ~$past(p_cell)) == 16'h0000) &&
                ((cell_q[$past(p_word)] & ~$past(clr_mask)) == 16'h0000) &&
                (((cell_q[$past(p_word)] ^ $past(p_cell)) & $past(clr_mask)) == 16'h0000)))
    else $error("array write set a bit or missed a clear");

  chk_cfg_apart: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    mem_we |-> (!preq_q.cfg && !preq_q.ptr_load)) else $error("array write aimed at configuration space");

  // Handshake shape: one answer pulse, refusals only ride on an answer
  chk_ack_single: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (prog_ack_o || cpu_ack_o) |=> !(prog_ack_o || cpu_ack_o))
    else $error("answer pulse longer than one cycle");

  chk_refused_pulse: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    refused_o |-> prog_ack_o) else $error("refusal without a programmer answer");

  chk_run_no_write: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (mem_we || cfg_we) |-> (is_prog_q && preq_q.we)) else $error("cell write outside a programmer write");

  // Independent count of sweep cycles, so the length check does not lean on the sweep's own counter
  logic [WORD_AW:0]    sweep_len_q;
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sweep_len_q <= '0;
    end else if (erase_q) begin
      sweep_len_q <= (WORD_AW+1)'(sweep_len_q + 1'b1);
    end else begin
      sweep_len_q <= '0;
    end
  end

  chk_sweep_len: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    $fell(erase_q) |-> (sweep_len_q == (WORD_AW+1)'(CELL_WORDS))) else $error("erase sweep length wrong");

  chk_erased_full: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    $fell(erase_q) |=> (sec_q == LVL_FULL)) else $error("erased part not at full access");
endmodule

// ===== verification/otp_programmer_model.sv
// Behavioural model of the external device programmer.
// Assumes the device samples requests on rising edges; this model drives on falling edges.
`timescale 1ns/1ps
module otp_programmer_model
  import otp_access_pkg::*;
(
  input  wire logic                 clk_sys_i,    // System clock
  input  wire logic                 prog_ready_i, // Request taken
  input  wire logic                 prog_ack_i,   // Answer pulse
  input  wire logic [7:0]           prog_rdata_i, // Read byte
  input  wire logic                 refused_i,    // Write refused
  output logic                      prog_valid_o, // Request valid
  output otp_access_pkg::prog_req_s prog_req_o    // Request fields
);
  // Idle bus at time zero
  initial begin
    prog_valid_o = 1'b0;
    prog_req_o   = '0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One request: hold until taken, then invert released fields so stale values never look valid
  task automatic xfer(input logic we, cfg, ptr, input logic [13:0] a, input logic [7:0] wd,
                      output logic [7:0] rd, output logic rf, output int lat);
    int n;
    n = 0;
    @(negedge clk_sys_i);
    prog_req_o   = '{we, cfg, ptr, a, wd};
    prog_valid_o = 1'b1;
    #1;
    while (prog_ready_i !== 1'b1 && n < 50) begin
      @(negedge clk_sys_i);
      #1;
      n++;
    end
    @(negedge clk_sys_i);
    prog_valid_o = 1'b0;
    prog_req_o   = ~prog_req_o;
    lat = 1;
    while (prog_ack_i !== 1'b1 && lat < 20) begin
      @(negedge clk_sys_i);
      lat++;
    end
    rd = prog_rdata_i;
    rf = refused_i;
  endtask

  // Configuration write always loads the pointer first and presents a matching address
  task automatic cfg_write(input logic [2:0] idx, input logic [7:0] wd);
    logic [7:0] rd;
    logic       rf;
    int         lat;
    xfer(1'b1, 1'b0, 1'b1, 14'h0000, {5'h00, idx}, rd, rf, lat);
    xfer(1'b1, 1'b1, 1'b0, {11'h000, idx}, wd, rd, rf, lat);
  endtask
endmodule

// ===== verification/otp_memory_mode_and_security_test.sv
// Self-checking bench for the program memory access block.
// Assumes the programmer model file is compiled first; all inputs change on falling edges.
`timescale 1ns/1ps
module otp_memory_mode_and_security_test;
  import otp_access_pkg::*;
  logic       clk_sys_i, sys_rst_i, prog_voltage_i, ext_mem_sel_i, uv_erase_i, cpu_valid_i;
  logic       prog_valid, prog_ready, prog_ack, refused, cpu_ready, cpu_ack, prog_mode, ext_q, busy;
  logic [7:0] prog_rdata;
  logic [15:0] cpu_rdata;
  logic [1:0] sec_level;
  prog_req_s  prog_req;
  cpu_req_s   cpu_req_i;
  int         err_count, num_checks, cycles;

  otp_memory_mode_and_security dut_u (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .prog_voltage_i(prog_voltage_i), .ext_mem_sel_i(ext_mem_sel_i), .uv_erase_i(uv_erase_i),
    .prog_valid_i(prog_valid), .prog_req_i(prog_req), .cpu_valid_i(cpu_valid_i), .cpu_req_i(cpu_req_i),
    .prog_ready_o(prog_ready), .prog_ack_o(prog_ack), .prog_rdata_o(prog_rdata), .cpu_ready_o(cpu_ready),
    .cpu_ack_o(cpu_ack), .cpu_rdata_o(cpu_rdata), .refused_o(refused), .prog_mode_o(prog_mode),
    .sec_level_o(sec_level), .ext_mem_sel_o(ext_q), .erase_busy_o(busy));
  otp_programmer_model prog_u (.clk_sys_i(clk_sys_i), .prog_ready_i(prog_ready), .prog_ack_i(prog_ack),
    .prog_rdata_i(prog_rdata), .refused_i(refused), .prog_valid_o(prog_valid), .prog_req_o(prog_req));

  ////////////////////////////////////////////////////////////////////////////
  // 250 MHz clock and a hang guard well past four erase sweeps
  initial begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 60000) begin
      err_count++;
      close_out();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [15:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic do_reset();
    sys_rst_i = 1'b1;
    repeat (12) @(negedge clk_sys_i);
    sys_rst_i = 1'b0;
    repeat (3) @(negedge clk_sys_i);
  endtask
  // Erase sweep, then two spare cycles for the level reload
  task automatic erase();
    int n;
    n = 0;
    @(negedge clk_sys_i);
    uv_erase_i = 1'b1;
    @(negedge clk_sys_i);
    uv_erase_i = 1'b0;
    while (busy === 1'b1 && n < 9000) begin
      @(negedge clk_sys_i);
      n++;
    end
    check("erase span", 16'(n), 16'(CELL_WORDS));
    repeat (2) @(negedge clk_sys_i);
  endtask
  task automatic prog(input logic we, cfg, ptr, input logic [13:0] a, input logic [7:0] wd, exp,
                      input logic rf);
    logic [7:0] rd;
    logic       rs;
    int         lat;
    prog_u.xfer(we, cfg, ptr, a, wd, rd, rs, lat);
    check("prog latency", 16'(lat), 16'h0002);
    check("prog refused", 16'(rs), 16'(rf));
    if (!we) check("prog rdata", {8'h00, rd}, {8'h00, exp});
  endtask
  task automatic cpu(input logic op, intl, vec, input logic [15:0] exp);
    int n;
    n = 0;
    @(negedge clk_sys_i);
    cpu_req_i   = '{op, intl, vec, 13'h0000};
    cpu_valid_i = 1'b1;
    #1;
    while (cpu_ready !== 1'b1 && n < 50) begin
      @(negedge clk_sys_i);
      #1;
      n++;
    end
    @(negedge clk_sys_i);
    cpu_valid_i = 1'b0;
    cpu_req_i   = ~cpu_req_i;
    n = 1;
    while (cpu_ack !== 1'b1 && n < 20) begin
      @(negedge clk_sys_i);
      n++;
    end
    check("cpu latency", 16'(n), 16'h0002);
    check("cpu rdata", cpu_rdata, exp);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Full-access run, then each locked level from a fresh erase
  initial begin
    sys_rst_i = 1'b1;
    prog_voltage_i = 1'b0;
    ext_mem_sel_i = 1'b1;
    uv_erase_i = 1'b0;
    cpu_valid_i = 1'b0;
    cpu_req_i = '0;
    err_count = 0;
    num_checks = 0;
    cycles = 0;
    do_reset();
    ext_mem_sel_i = 1'b0;
    erase();
    check("ext select", 16'(ext_q), 16'h0001);
    check("erased level", 16'(sec_level), 16'(LVL_FULL));
    prog_voltage_i = 1'b1;
    @(negedge clk_sys_i);
    check("prog mode", 16'(prog_mode), 16'h0001);
    prog(1'b1, 1'b0, 1'b0, 14'h0000, 8'h3C, 8'h00, 1'b0);
    prog(1'b1, 1'b0, 1'b0, 14'h0000, 8'hF0, 8'h00, 1'b0);
    prog(1'b0, 1'b0, 1'b0, 14'h0000, 8'h00, 8'h30, 1'b0);
    prog(1'b0, 1'b0, 1'b0, 14'h3FFF, 8'h00, 8'hFF, 1'b0);
    prog(1'b1, 1'b0, 1'b1, 14'h0000, 8'h06, 8'h00, 1'b0);
    prog(1'b1, 1'b1, 1'b0, 14'h0007, 8'h00, 8'h00, 1'b1);
    prog(1'b1, 1'b1, 1'b0, 14'h0006, 8'h0F, 8'h00, 1'b0);
    prog(1'b0, 1'b1, 1'b0, 14'h0006, 8'h00, 8'h0F, 1'b0);
    prog(1'b0, 1'b1, 1'b0, 14'h0007, 8'h00, 8'hFF, 1'b0);
    prog(1'b0, 1'b0, 1'b0, 14'h0006, 8'h00, 8'hFF, 1'b0);
    prog_voltage_i = 1'b0;
    @(negedge clk_sys_i);
    check("run mode", 16'(prog_mode), 16'h0000);
    cpu(1'b1, 1'b0, 1'b0, 16'hFF30);
    for (int lv = 2; lv >= 0; lv--) begin
      erase();
      prog_voltage_i = 1'b1;
      prog(1'b1, 1'b0, 1'b0, 14'h0000, 8'h3C, 8'h00, 1'b0);
      prog_u.cfg_write(3'h7, {6'h3F, 2'(lv)});
      prog_voltage_i = 1'b0;
      do_reset();
      check("level", 16'(sec_level), 16'(lv));
      check("ext relatch", 16'(ext_q), 16'h0000);
      cpu(1'b1, 1'b0, 1'b0, (lv == 2) ? 16'hFF3C : 16'hFFFF);
      cpu(1'b1, 1'b1, 1'b0, 16'hFF3C);
      cpu(1'b1, 1'b0, 1'b1, 16'hFF3C);
      cpu(1'b0, 1'b0, 1'b0, 16'hFF3C);
      prog_voltage_i = 1'b1;
      prog(1'b1, 1'b0, 1'b0, 14'h0000, 8'h00, 8'h00, 1'b1);
      prog(1'b0, 1'b0, 1'b0, 14'h0000, 8'h00,
           (lv == 2) ? 8'h3C : (lv == 1) ? (8'h3C ^ ENCRYPT_KEY) : ERASED_BYTE, 1'b0);
      prog(1'b0, 1'b1, 1'b0, 14'h0007, 8'h00, {6'h3F, 2'(lv)}, 1'b0);
      prog_voltage_i = 1'b0;
    end
    close_out();
  end
endmodule
